// [mah_pkg.sv]
// Functional notes
// R1: Converter pulls the completion flag low when each conversion finishes.
// R2: Sample strobe low with device select low starts sampling and conversion.
// R3: Read strobe and device select both low put the result on the bus.
// R4: Converter ignores both strobes while device select is high.
// R5: Channel lines captured on sample strobe falling edge; host holds them valid.
// R6: Four-input variant decodes two select bits; two-input variant uses one.
// R7: Result is straight binary, zero at low reference, 1023 at top; the converter model puts the channel code in the lowest two bits.
// R8: Result bus is ten bits, three-state, driven only during a qualified read; the converter model drives the inverse of the last result otherwise.
// R9: Conversion ends about 360 ns typical, 466 ns at most after start.
// R10: Successive conversions may start at 1.5 MHz or faster.
// R11: Converter looks like one memory location driven by plain bus strobes.
// R12: Conversion is self-timed; no clock goes to the converter.
// R13: Each result comes from a coarse flash step then a fine step.
// R14: Completion flag returns high after the rising edge of the read strobe.
// R15: Host waits for the completion flag low before asserting read.
package mah_pkg;

  localparam int unsigned CLOCK_HZ         = 25000000;
  localparam int unsigned CONV_MAX_NS      = 466;
  localparam int unsigned SAMPLE_PERIOD_NS = 667;
  localparam int unsigned STROBE_MIN_NS    = 80;
  localparam int unsigned SETUP_MIN_NS     = 40;
  localparam int unsigned RESULT_WIDTH     = 10;
  localparam int unsigned CHANNELS_MAX     = 4;
  localparam int unsigned FIFO_DEPTH       = 32;
  localparam logic [9:0]  RESULT_MAX       = 10'h3FF;

  // Strobe and setup times round up to whole cycles, conversion rounds up plus one cycle; the sample period rounds down.
  localparam int unsigned CONV_CYCLES    = (CONV_MAX_NS * 25 + 999) / 1000 + 1;
  localparam int unsigned PERIOD_CYCLES  = (SAMPLE_PERIOD_NS * 25) / 1000;
  localparam int unsigned STROBE_CYCLES  = (STROBE_MIN_NS * 25 + 999) / 1000;
  localparam int unsigned SETUP_CYCLES   = (SETUP_MIN_NS * 25 + 999) / 1000;

  typedef enum logic [2:0] {
    MAH_IDLE   = 3'b000,
    MAH_SETUP  = 3'b001,
    MAH_SAMPLE = 3'b010,
    MAH_WAIT   = 3'b011,
    MAH_READ   = 3'b100,
    MAH_FINISH = 3'b101
  } mah_state_type;

endpackage : mah_pkg

// [mah_stream_if.sv]
`timescale 1ns/1ps
interface mah_stream_if #(
  parameter int unsigned WIDTH = 12
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : mah_stream_if

// [mah_fifo.sv]
`timescale 1ns/1ps
module mah_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic      clock_in,
  input  wire logic      rstn_in,
  mah_stream_if.sink     wr,
  mah_stream_if.source   rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("FIFO depth must be a power of two of at least 2.");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  assign full     = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign empty    = (wptr_reg == rptr_reg);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_reg[rptr_reg[AW-1:0]];
  assign do_wr    = wr.valid && !full;
  assign do_rd    = rd.ready && !empty;

  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem_reg[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (do_wr) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_rd) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end

endmodule : mah_fifo

// [mah_host.sv]
`timescale 1ns/1ps
module mah_host #(
  parameter int unsigned CHANNELS    = 4,
  parameter int unsigned FIFO_DEPTH  = mah_pkg::FIFO_DEPTH,
  parameter int unsigned TIMEOUT_CYC = 64
) (
  input  wire logic       clock_in,
  input  wire logic       rstn_in,
  input  wire logic       start_in,
  input  wire logic       continuous_in,
  input  wire logic [1:0] channel_in,
  output logic            busy_out,
  output logic            timeout_out,
  output logic            sample_valid_out,
  input  wire logic       sample_ready_in,
  output logic [1:0]      sample_channel_out,
  output logic [9:0]      sample_data_out,
  output logic            select_n_out,
  output logic            sample_n_out,
  output logic            read_n_out,
  output logic            channel_select_lsb_out,
  output logic            channel_select_msb_out,
  input  wire logic       done_n_in,
  input  wire logic [9:0] result_bus_in
);

  initial begin
    if (CHANNELS != 2 && CHANNELS != mah_pkg::CHANNELS_MAX) begin
      $error("CHANNELS must be 2 or 4.");
    end
    if (TIMEOUT_CYC <= mah_pkg::CONV_CYCLES || TIMEOUT_CYC > 255) begin
      $error("TIMEOUT_CYC must exceed the conversion time and fit eight bits.");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  logic [1:0]  done_sync_reg;
  logic [9:0]  bus_s1_reg;
  logic [9:0]  bus_s2_reg;
  logic        done_n;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      done_sync_reg <= 2'h3;
      bus_s1_reg    <= 10'h000;
      bus_s2_reg    <= 10'h000;
    end else begin
      done_sync_reg <= {done_sync_reg[0], done_n_in};
      bus_s1_reg    <= result_bus_in;
      bus_s2_reg    <= bus_s1_reg;
    end
  end
  assign done_n = done_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer driving the converter's strobes.

  mah_pkg::mah_state_type state_reg;
  mah_pkg::mah_state_type state_next;
  logic [7:0]             cnt_reg;
  logic [7:0]             cnt_next;
  logic [7:0]             period_reg;
  logic [1:0]             chan_reg;
  logic [9:0]             data_reg;
  logic                   timeout_reg;
  logic                   pending_reg;
  logic                   push;
  logic                   room;
  logic [1:0]             chan_pick;

  mah_stream_if #(.WIDTH(12)) fill_if ();
  mah_stream_if #(.WIDTH(12)) drain_if ();

  assign room = fill_if.ready;

  // Keeps the channel code legal for the fitted variant.
  function automatic logic [1:0] legal_chan(input logic [1:0] c);
    legal_chan = (CHANNELS == 2) ? {1'b0, c[0]} : c; // [R6]
  endfunction : legal_chan

  assign chan_pick = legal_chan(channel_in);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 8'h01;
    push       = 1'b0;
    unique case (state_reg)
      mah_pkg::MAH_IDLE: begin
        cnt_next = 8'h00;
        if ((pending_reg || start_in) && room &&
            period_reg >= 8'(mah_pkg::PERIOD_CYCLES)) begin // [R10]
          state_next = mah_pkg::MAH_SETUP;
        end
      end
      mah_pkg::MAH_SETUP: begin
        if (cnt_reg + 8'h01 >= 8'(mah_pkg::SETUP_CYCLES)) begin // [R5]
          state_next = mah_pkg::MAH_SAMPLE;
          cnt_next   = 8'h00;
        end
      end
      mah_pkg::MAH_SAMPLE: begin
        if (cnt_reg + 8'h01 >= 8'(mah_pkg::STROBE_CYCLES)) begin
          state_next = mah_pkg::MAH_WAIT;
          cnt_next   = 8'h00;
        end
      end
      mah_pkg::MAH_WAIT: begin
        if (!done_n) begin // [R1] [R15]
          state_next = mah_pkg::MAH_READ;
          cnt_next   = 8'h00;
        end else if (cnt_reg + 8'h01 >= 8'(TIMEOUT_CYC)) begin // [R9] [R12]
          state_next = mah_pkg::MAH_FINISH;
          cnt_next   = 8'h00;
        end
      end
      mah_pkg::MAH_READ: begin
        // Strobe minimum plus two sync stages before the bus is trusted.
        if (cnt_reg + 8'h01 >= 8'(mah_pkg::STROBE_CYCLES + 2)) begin // [R3] [R8]
          state_next = mah_pkg::MAH_FINISH;
          cnt_next   = 8'h00;
          push       = 1'b1;
        end
      end
      mah_pkg::MAH_FINISH: begin
        state_next = mah_pkg::MAH_IDLE;
      end
      default: begin
        state_next = mah_pkg::MAH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= mah_pkg::MAH_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Cycles since the last sample strobe, saturating.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      period_reg <= 8'hFF;
    end else if (state_reg == mah_pkg::MAH_SAMPLE && cnt_reg == 8'h00) begin
      period_reg <= 8'h01;
    end else if (period_reg != 8'hFF) begin
      period_reg <= period_reg + 8'h01;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      chan_reg    <= 2'h0;
      pending_reg <= 1'b0;
    end else if (state_reg == mah_pkg::MAH_IDLE && state_next == mah_pkg::MAH_SETUP) begin
      chan_reg    <= legal_chan(channel_in);
      pending_reg <= continuous_in;
    end else if (state_reg == mah_pkg::MAH_IDLE && !continuous_in) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      timeout_reg <= 1'b0;
    end else if (state_reg == mah_pkg::MAH_WAIT && state_next == mah_pkg::MAH_FINISH) begin
      timeout_reg <= 1'b1;
    end else if (state_reg == mah_pkg::MAH_SETUP) begin
      timeout_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= 10'h000;
    end else if (push) begin
      data_reg <= bus_s2_reg; // [R7] [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all from flip-flops.

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      select_n_out           <= 1'b1;
      sample_n_out           <= 1'b1;
      read_n_out             <= 1'b1;
      channel_select_lsb_out <= 1'b0;
      channel_select_msb_out <= 1'b0;
    end else begin
      // Device select frames only the strobes, so the converter ignores the bus otherwise.
      select_n_out <= !(state_next == mah_pkg::MAH_SAMPLE ||
                        state_next == mah_pkg::MAH_READ); // [R4] [R11]
      sample_n_out <= !(state_next == mah_pkg::MAH_SAMPLE); // [R2]
      read_n_out   <= !(state_next == mah_pkg::MAH_READ); // [R3] [R14]
      if (state_next == mah_pkg::MAH_SETUP) begin
        channel_select_lsb_out <= chan_pick[0]; // [R5] [R6]
        channel_select_msb_out <= chan_pick[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result buffer.

  logic push_reg;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      push_reg <= 1'b0;
    end else begin
      push_reg <= push;
    end
  end

  assign fill_if.valid   = push_reg;
  assign fill_if.data    = {chan_reg, data_reg};
  assign drain_if.ready  = sample_ready_in;

  mah_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in (clock_in),
    .rstn_in  (rst_n),
    .wr       (fill_if.sink),
    .rd       (drain_if.source)
  );

  assign sample_valid_out   = drain_if.valid;
  assign sample_channel_out = drain_if.data[11:10];
  assign sample_data_out    = drain_if.data[9:0];
  assign busy_out           = (state_reg != mah_pkg::MAH_IDLE);
  assign timeout_out        = timeout_reg;

endmodule : mah_host

// [mah_host_checker.sv]
`timescale 1ns/1ps
module mah_host_checker (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic busy_out,
  input wire logic select_n_out,
  input wire logic sample_n_out,
  input wire logic read_n_out,
  input wire logic channel_select_lsb_out,
  input wire logic channel_select_msb_out,
  input wire logic done_n_in
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic [5:0] gap_reg;
  // Counts cycles since the last sample strobe began, saturating.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in)
      gap_reg <= 6'h3F;
    else if ($fell(sample_n_out))
      gap_reg <= 6'h00;
    else if (gap_reg != 6'h3F)
      gap_reg <= gap_reg + 6'h01;
  end
  a_sample_selected: assert property (!sample_n_out |-> !select_n_out)
    else $error("sample strobe without select");
  a_read_selected: assert property (!read_n_out |-> !select_n_out)
    else $error("read strobe without select");
  a_strobes_apart: assert property (!(!read_n_out && !sample_n_out))
    else $error("read and sample together");
  a_read_after_flag: assert property ($fell(read_n_out) |-> !$past(done_n_in, 2))
    else $error("read before completion flag");
  a_read_width: assert property ($fell(read_n_out) |-> !read_n_out[*4] ##1 read_n_out)
    else $error("read strobe width wrong");
  a_sample_width: assert property ($fell(sample_n_out) |-> !sample_n_out[*2] ##1 sample_n_out)
    else $error("sample strobe width wrong");
  a_channel_held: assert property (!sample_n_out |->
    $stable({channel_select_msb_out, channel_select_lsb_out}))
    else $error("channel lines moved during sample");
  a_sample_spacing: assert property ($fell(sample_n_out) |-> gap_reg >= 6'h10)
    else $error("sample strobes too close");
  a_idle_quiet: assert property (!busy_out |-> select_n_out && sample_n_out && read_n_out)
    else $error("strobe active while idle");
endmodule : mah_host_checker

// [mah_conv_model.sv]
`timescale 1ns/1ps
module mah_conv_model #(
  parameter int unsigned FAST_NS = 360,
  parameter int unsigned SLOW_NS = 466
) (
  input  wire logic       select_n_in,
  input  wire logic       sample_n_in,
  input  wire logic       read_n_in,
  input  wire logic       channel_select_lsb_in,
  input  wire logic       channel_select_msb_in,
  input  wire logic [9:0] level_in,
  input  wire logic       slow_in,
  input  wire logic       mute_in,
  output logic            done_n_out,
  output logic [9:0]      result_bus_out
);
  logic [9:0] result_reg;
  logic [9:0] held_reg;
  logic [1:0] channel_reg;
  logic       reading;
  assign reading = !read_n_in && !select_n_in;
  // Off the bus, the lines show the inverse of the last result.
  assign result_bus_out = reading ? result_reg : ~result_reg;
  initial begin
    done_n_out = 1'b1;
    result_reg = 10'h000;
  end
  always @(posedge (!sample_n_in && !select_n_in)) begin
    channel_reg = {channel_select_msb_in, channel_select_lsb_in};
    held_reg = level_in;
    done_n_out = 1'b1;
    #(slow_in ? SLOW_NS : FAST_NS);
    // Upper bits follow the held input, the lowest two mark the channel.
    result_reg = {held_reg[9:2], channel_reg};
    if (!mute_in)
      done_n_out = 1'b0;
  end
  always @(negedge reading) done_n_out = 1'b1;
endmodule : mah_conv_model

// [mah_host_tb.sv]
`timescale 1ns/1ps
module mah_host_tb;
  logic        clock_in, rstn_in, start_in, continuous_in, sample_ready_in, slow, mute;
  logic        busy_out, timeout_out, sample_valid_out, sel_n, smp_n, rd_n, lsb, msb;
  logic        done_n, prev_smp_n;
  logic [1:0]  channel_in, sample_channel_out;
  logic [9:0]  level, sample_data_out, bus;
  logic [31:0] seed, r;
  logic [11:0] exp_q[$];
  logic        busy2, tmo2, valid2, sel2_n, smp2_n, rd2_n, lsb2, msb2, done2_n, prev_smp2_n;
  logic [1:0]  ch2;
  logic [9:0]  data2, bus2;
  logic [11:0] exp2_q[$];
  int          mismatches, checks_done;

  mah_host dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .start_in(start_in), .continuous_in(continuous_in),
    .channel_in(channel_in), .busy_out(busy_out), .timeout_out(timeout_out),
    .sample_valid_out(sample_valid_out), .sample_ready_in(sample_ready_in),
    .sample_channel_out(sample_channel_out), .sample_data_out(sample_data_out),
    .select_n_out(sel_n), .sample_n_out(smp_n), .read_n_out(rd_n),
    .channel_select_lsb_out(lsb), .channel_select_msb_out(msb), .done_n_in(done_n),
    .result_bus_in(bus));
  mah_conv_model conv (
    .select_n_in(sel_n), .sample_n_in(smp_n), .read_n_in(rd_n), .channel_select_lsb_in(lsb),
    .channel_select_msb_in(msb), .level_in(level), .slow_in(slow), .mute_in(mute),
    .done_n_out(done_n), .result_bus_out(bus));
  // Two-input variant on the same stimulus; its upper channel bit must stay clear.
  mah_host #(.CHANNELS(2)) dut2 (
    .clock_in(clock_in), .rstn_in(rstn_in), .start_in(start_in), .continuous_in(continuous_in),
    .channel_in(channel_in), .busy_out(busy2), .timeout_out(tmo2),
    .sample_valid_out(valid2), .sample_ready_in(sample_ready_in),
    .sample_channel_out(ch2), .sample_data_out(data2),
    .select_n_out(sel2_n), .sample_n_out(smp2_n), .read_n_out(rd2_n),
    .channel_select_lsb_out(lsb2), .channel_select_msb_out(msb2), .done_n_in(done2_n),
    .result_bus_in(bus2));
  mah_conv_model conv2 (
    .select_n_in(sel2_n), .sample_n_in(smp2_n), .read_n_in(rd2_n), .channel_select_lsb_in(lsb2),
    .channel_select_msb_in(msb2), .level_in(level), .slow_in(slow), .mute_in(mute),
    .done_n_out(done2_n), .result_bus_out(bus2));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check_word(input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask : check_word
  task automatic check_flag(input logic exp, input logic got);
    check_word({11'h000, exp}, {11'h000, got});
  endtask : check_flag
  task automatic wait_busy(input logic want);
    for (int n = 0; n < 300 && busy_out !== want; n++) @(posedge clock_in);
  endtask : wait_busy
  task automatic convert();
    start_in <= 1'b1;
    wait_busy(1'b1);
    start_in <= 1'b0;
    wait_busy(1'b0);
    repeat (4) @(posedge clock_in);
  endtask : convert
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // Each qualified sample strobe with the converter unmuted owes one word; every popped word is compared.
  always @(posedge clock_in) begin
    prev_smp_n <= smp_n;
    if (prev_smp_n && !smp_n && !sel_n && !mute)
      exp_q.push_back({channel_in, level[9:2], channel_in});
    if (rstn_in && sample_valid_out && sample_ready_in)
      check_word(exp_q.size() > 0 ? exp_q.pop_front() : 12'hXXX,
                 {sample_channel_out, sample_data_out});
    prev_smp2_n <= smp2_n;
    if (prev_smp2_n && !smp2_n && !sel2_n && !mute)
      exp2_q.push_back({1'b0, channel_in[0], level[9:2], 1'b0, channel_in[0]});
    if (rstn_in && valid2 && sample_ready_in)
      check_word(exp2_q.size() > 0 ? exp2_q.pop_front() : 12'hXXX, {ch2, data2});
  end
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    finish_test();
  end
  initial begin
    rstn_in = 1'b0;
    start_in = 1'b0;
    continuous_in = 1'b0;
    sample_ready_in = 1'b1;
    slow = 1'b0;
    mute = 1'b0;
    channel_in = 2'h0;
    level = 10'h000;
    seed = 32'hA49ACE89;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    // Every channel with fast and slow converter, both ends of the code range.
    for (int i = 0; i < 8; i++) begin
      r = xs();
      slow <= i[2];
      channel_in <= i[1:0];
      level <= (i == 0) ? 10'h000 : (i == 7) ? 10'h3FF : r[9:0];
      convert();
    end
    mute <= 1'b1;
    convert();
    check_flag(1'b1, timeout_out);
    check_flag(1'b1, tmo2);
    mute <= 1'b0;
    convert();
    check_flag(1'b0, timeout_out);
    check_flag(1'b0, tmo2);
    // Fill the buffer with the reader stalled, then drain at a random pace.
    // Continuous mode needs one start to arm it.
    sample_ready_in <= 1'b0;
    continuous_in <= 1'b1;
    start_in <= 1'b1;
    wait_busy(1'b1);
    start_in <= 1'b0;
    for (int n = 0; n < 3000 && (exp_q.size() < 32 || exp2_q.size() < 32); n++)
      @(posedge clock_in);
    repeat (100) @(posedge clock_in);
    check_word(12'h020, 12'(exp_q.size()));
    check_word(12'h020, 12'(exp2_q.size()));
    continuous_in <= 1'b0;
    for (int n = 0; n < 600 && (exp_q.size() > 0 || exp2_q.size() > 0); n++) begin
      r = xs();
      sample_ready_in <= r[0];
      @(posedge clock_in);
    end
    repeat (2) @(posedge clock_in);
    check_flag(1'b0, sample_valid_out);
    check_flag(1'b0, valid2);
    finish_test();
  end
endmodule : mah_host_tb

bind mah_host mah_host_checker u_chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .busy_out(busy_out), .select_n_out(select_n_out),
  .sample_n_out(sample_n_out), .read_n_out(read_n_out), .done_n_in(done_n_in),
  .channel_select_lsb_out(channel_select_lsb_out),
  .channel_select_msb_out(channel_select_msb_out));
